// ===== design/ccitt_stream_packer.sv
// bi-level code stream packer: scheme select, colour sense, octet packing
`timescale 1ns/1ns
module ccitt_stream_packer
  import ccitt_pack_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire logic               seg_start,
  input  wire logic               seg_end,
  input  wire logic [15:0]        compression_sel,
  input  wire logic               order_given,
  input  wire logic [15:0]        bit_packing_order,
  input  wire logic               colour_sense_setting,
  input  wire logic               code_valid,
  input  wire logic [CODE_W-1:0]  code_bits,
  input  wire logic [CLEN_W-1:0]  code_len,
  input  wire logic               mkup_valid,
  input  wire logic [RUN_W-1:0]   mkup_run,
  output logic                    in_ready,
  input  wire logic               run_valid,
  input  wire logic               run_black,
  output logic                    pix_valid,
  output logic                    pix_value,
  output logic                    byte_valid,
  output logic [OCTET_W-1:0]      byte_data,
  output logic                    seg_done,
  output logic [BYTES_W-1:0]      seg_bytes,
  output logic                    restart,
  output logic                    scheme_g3,
  output logic                    scheme_g4,
  output logic                    link_order_flag,
  output logic                    order_unset,
  output logic                    mode_bad,
  output logic                    run_bad,
  output logic                    busy
);

  code_if cw ();

  seq_state_e         st_q;
  seq_state_e         st_d;
  logic               g3_q;
  logic               g4_q;
  logic               lsb_q;
  logic               dark_q;
  logic               link_q;
  logic               unset_q;
  logic               mbad_q;
  logic               rbad_q;
  logic               rdy_q;
  logic               hold_q;
  code_word_t         hbits_q;
  logic [LEN_W-1:0]   hlen_q;
  logic               restart_q;
  logic               done_q;
  logic [BYTES_W-1:0] nbytes_q;
  logic               pv_q;
  logic               pix_q;
  logic               take;
  logic               drain;
  logic               hold_d;
  logic               sel_ok;
  logic               order_lsb;
  logic               order_ok;
  logic [MK_W-1:0]    mk_code;
  logic [LEN_W-1:0]   mk_len;
  logic               mk_legal;
  logic               start_ok;
  logic               busy_q;

  makeup_table u_mkup (
    .run_len  (mkup_run),
    .code     (mk_code),
    .code_len (mk_len),
    .legal    (mk_legal)
  );

  octet_packer u_pack (
    .clk_sys (clk_sys),
    .rst     (rst),
    .cw      (cw.sink)
  );

  // configuration decode at segment start
  always_comb begin
    sel_ok    = (compression_sel == SCHEME_G3) ||
                (compression_sel == SCHEME_G4);
    // an absent order is taken as order 1
    order_lsb = order_given &&
                (bit_packing_order == ORDER_LSB_FIRST);
    order_ok  = !order_given ||
                (bit_packing_order == ORDER_MSB_FIRST) ||
                (bit_packing_order == ORDER_LSB_FIRST);
  end

  // handshakes: user word taken, held word drained into the packer
  assign take  = rdy_q && (code_valid || mkup_valid);
  assign drain = hold_q && cw.ready;

  // a start is only heard while idle or halted
  assign start_ok = seg_start && (st_q == ST_IDLE || st_q == ST_HALT);

  // segment sequencer next state
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE: begin
        if (seg_start) begin
          st_d = sel_ok ? ST_RUN : ST_HALT;
        end
      end
      ST_RUN: begin
        // group 3 has no trailer, only the zero padding
        if (rdy_q && seg_end && !take) begin
          st_d = g4_q ? ST_EOFB : ST_FLUSH;
        end
      end
      ST_EOFB: begin
        // trailer loads once the last word has left the hold stage
        if (!hold_q) begin
          st_d = ST_FLUSH;
        end
      end
      ST_FLUSH: begin
        if (cw.flushed) begin
          st_d = ST_IDLE;
        end
      end
      ST_HALT: begin
        // a bad selector waits for the next segment start
        if (seg_start && sel_ok) begin
          st_d = ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q <= ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // segment configuration latched once per segment
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      g3_q    <= 1'b0;
      g4_q    <= 1'b0;
      lsb_q   <= 1'b0;
      dark_q  <= ZERO_MEANS_LIGHT;
      link_q  <= 1'b0;
      unset_q <= 1'b0;
      mbad_q  <= 1'b0;
    end else if (start_ok) begin
      g3_q    <= (compression_sel == SCHEME_G3);
      g4_q    <= (compression_sel == SCHEME_G4);
      lsb_q   <= order_lsb;
      dark_q  <= (colour_sense_setting == ZERO_MEANS_DARK);
      link_q  <= order_lsb;
      unset_q <= !order_given;
      // an unknown selector or order value is reported here
      mbad_q  <= !sel_ok || !order_ok;
    end
  end

  // one-stage holding register in front of the packer
  always_comb begin
    hold_d = hold_q;
    if (drain) begin
      hold_d = 1'b0;
    end
    if (take || (st_q == ST_EOFB && !hold_q)) begin
      hold_d = 1'b1;
    end
  end

  // words are accepted without inspection, so fill and eol codes pass
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hold_q  <= 1'b0;
      hbits_q <= '0;
      hlen_q  <= '0;
    end else begin
      hold_q <= hold_d;
      if (take && mkup_valid) begin
        hbits_q <= code_word_t'(mk_code);
        hlen_q  <= mk_len;
      end else if (take) begin
        hbits_q <= code_word_t'(code_bits);
        hlen_q  <= LEN_W'(code_len);
      end else if (st_q == ST_EOFB && !hold_q) begin
        hbits_q <= EOFB_CODE;
        hlen_q  <= EOFB_LEN;
      end
    end
  end

  // illegal make-up run length is sticky until the next segment
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rbad_q <= 1'b0;
    // take never falls in idle or halt, so set and clear cannot meet
    end else if (start_ok) begin
      rbad_q <= 1'b0;
    end else if (take && mkup_valid && !mk_legal) begin
      rbad_q <= 1'b1;
    end
  end

  // ready is registered, and its next value drops for the word taken this cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdy_q <= 1'b0;
    end else begin
      rdy_q <= (st_d == ST_RUN) && !hold_d && !take;
    end
  end

  // packer side of the hand-off
  assign cw.valid     = hold_q;
  assign cw.bits      = hbits_q;
  assign cw.len       = hlen_q;
  assign cw.lsb_first = lsb_q;
  assign cw.flush     = (st_q == ST_FLUSH) && !hold_q;

  // restart pulse tells the coder to drop its reference line
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= start_ok && sel_ok;
    end
  end

  // done pulse and octet count; a new segment always starts a fresh byte
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      done_q   <= 1'b0;
      nbytes_q <= '0;
    end else begin
      done_q <= (st_q == ST_FLUSH) && cw.flushed;
      if (restart_q) begin
        nbytes_q <= '0;
      end else if (cw.byte_valid) begin
        nbytes_q <= nbytes_q + 16'h0001;
      end
    end
  end

  // colour sense mapping of decoded runs to pixel values
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pv_q  <= 1'b0;
      pix_q <= 1'b0;
    end else begin
      pv_q <= run_valid;
      if (run_valid) begin
        pix_q <= run_black ^ dark_q;
      end
    end
  end

  // busy has its own flop so the output is registered, not decoded
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (st_d != ST_IDLE) && (st_d != ST_HALT);
    end
  end

  // every output below is a plain register copy
  assign in_ready        = rdy_q;
  assign pix_valid       = pv_q;
  assign pix_value       = pix_q;
  assign byte_valid      = cw.byte_valid;
  assign byte_data       = cw.byte_data;
  assign seg_done        = done_q;
  assign seg_bytes       = nbytes_q;
  assign restart         = restart_q;
  assign scheme_g3       = g3_q;
  assign scheme_g4       = g4_q;
  assign link_order_flag = link_q;
  assign order_unset     = unset_q;
  assign mode_bad        = mbad_q;
  assign run_bad         = rbad_q;
  assign busy            = busy_q;

endmodule : ccitt_stream_packer

// ===== include/ccitt_pack_pkg.sv
// constants, codes and types shared by the bi-level stream packer
package ccitt_pack_pkg;

  // compression selector values
  localparam logic [15:0] SCHEME_G3 = 16'h0003;
  localparam logic [15:0] SCHEME_G4 = 16'h0004;

  // bit packing order values
  localparam logic [15:0] ORDER_MSB_FIRST = 16'h0001;
  localparam logic [15:0] ORDER_LSB_FIRST = 16'h0002;

  // colour sense setting encodings
  localparam logic ZERO_MEANS_LIGHT = 1'b0;
  localparam logic ZERO_MEANS_DARK  = 1'b1;

  // widths
  localparam int WORD_W  = 24;
  localparam int LEN_W   = 5;
  localparam int OCTET_W = 8;
  localparam int CNT_W   = 3;
  localparam int CODE_W  = 13;
  localparam int CLEN_W  = 4;
  localparam int RUN_W   = 12;
  localparam int MK_W    = 11;
  localparam int MK_IDX_W = 4;
  localparam int BYTES_W = 16;

  // end of facsimile block, sent after the last line in group 4
  localparam logic [WORD_W-1:0] EOFB_CODE = 24'h001001;
  localparam logic [LEN_W-1:0]  EOFB_LEN  = 5'h18;

  // shared make-up codes: run 1792 upward in steps of 64
  localparam logic [RUN_W-1:0]    MKUP_BASE  = 12'h700;
  localparam logic [RUN_W-1:0]    MKUP_LAST  = 12'hA00;
  localparam int                  MKUP_SHIFT = 6;
  localparam logic [MK_IDX_W-1:0] MKUP_CNT   = 4'hD;
  localparam logic [MK_W-1:0] MKUP_CODE [13] = '{
    11'h008, 11'h00C, 11'h00D, 11'h012, 11'h013, 11'h014, 11'h015,
    11'h016, 11'h017, 11'h01C, 11'h01D, 11'h01E, 11'h01F};
  localparam logic [MK_IDX_W-1:0] MKUP_SHORT = 4'h3; // first three 10 bits
  localparam logic [LEN_W-1:0]    MKUP_LEN10 = 5'h0A;
  localparam logic [LEN_W-1:0]    MKUP_LEN11 = 5'h0B;

  // segment sequencer states
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_RUN   = 5'h02,
    ST_EOFB  = 5'h04,
    ST_FLUSH = 5'h08,
    ST_HALT  = 5'h10
  } seq_state_e;

  typedef logic [WORD_W-1:0] code_word_t;

endpackage : ccitt_pack_pkg

// ===== include/code_if.sv
// codeword hand-off between the sequencer and the octet packer
`timescale 1ns/1ns
interface code_if;
  import ccitt_pack_pkg::*;
  logic                  valid;
  logic                  ready;
  code_word_t            bits;
  logic [LEN_W-1:0]      len;
  logic                  lsb_first;
  logic                  flush;
  logic                  flushed;
  logic                  byte_valid;
  logic [OCTET_W-1:0]    byte_data;

  modport src  (output valid, output bits, output len, output lsb_first,
                output flush, input ready, input flushed,
                input byte_valid, input byte_data);
  modport sink (input valid, input bits, input len, input lsb_first,
                input flush, output ready, output flushed,
                output byte_valid, output byte_data);
endinterface : code_if

// ===== design/makeup_table.sv
// shared long-run make-up codeword lookup
`timescale 1ns/1ns
module makeup_table
  import ccitt_pack_pkg::*;
(
  input  wire logic [RUN_W-1:0] run_len,
  output logic      [MK_W-1:0]  code,
  output logic      [LEN_W-1:0] code_len,
  output logic                  legal
);

  logic [RUN_W-1:0]    offset;
  logic [MK_IDX_W-1:0] idx;

  // index from run length; only exact multiples of 64 in range are legal
  always_comb begin
    offset   = run_len - MKUP_BASE;
    idx      = offset[MKUP_SHIFT +: MK_IDX_W];
    legal    = (run_len >= MKUP_BASE) && (run_len <= MKUP_LAST) &&
               (offset[MKUP_SHIFT-1:0] == '0);
    code     = '0;
    code_len = '0;
    if (legal && idx < MKUP_CNT) begin
      code     = MKUP_CODE[idx];
      code_len = (idx < MKUP_SHORT) ? MKUP_LEN10 : MKUP_LEN11;
    end
  end

endmodule : makeup_table

// ===== design/octet_packer.sv
// serial codeword to octet packer with zero padding on flush
`timescale 1ns/1ns
module octet_packer
  import ccitt_pack_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst,
  code_if.sink      cw
);

  code_word_t         word_q;
  logic [LEN_W-1:0]   rem_q;
  logic [OCTET_W-1:0] acc_q;
  logic [CNT_W-1:0]   cnt_q;
  logic               lsb_q;
  logic               bv_q;
  logic [OCTET_W-1:0] bd_q;
  logic               fl_q;
  logic               cur_bit;
  logic [OCTET_W-1:0] acc_n;
  logic [CNT_W-1:0]   pos;

  // ready only when the previous codeword has fully drained
  assign cw.ready      = (rem_q == '0) && !cw.flush;
  assign cw.byte_valid = bv_q;
  assign cw.byte_data  = bd_q;
  assign cw.flushed    = fl_q;

  // next accumulator with the current serial bit placed
  always_comb begin
    cur_bit = word_q[rem_q - 5'h01];
    pos     = lsb_q ? cnt_q : ~cnt_q;
    acc_n   = acc_q;
    acc_n[pos] = cur_bit;
  end

  // one bit per cycle, octet emitted on the eighth bit
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      word_q <= '0;
      rem_q  <= '0;
      acc_q  <= '0;
      cnt_q  <= '0;
      lsb_q  <= 1'b0;
      bv_q   <= 1'b0;
      bd_q   <= '0;
      fl_q   <= 1'b0;
    end else begin
      bv_q <= 1'b0;
      fl_q <= 1'b0;
      if (cw.valid && cw.ready) begin
        word_q <= cw.bits;
        rem_q  <= cw.len;
        lsb_q  <= cw.lsb_first;
      end else if (rem_q != '0) begin
        rem_q <= rem_q - 5'h01;
        cnt_q <= cnt_q + 3'h1;
        if (cnt_q == 3'h7) begin
          bv_q  <= 1'b1;
          bd_q  <= acc_n;
          acc_q <= '0;
        end else begin
          acc_q <= acc_n;
        end
      end else if (cw.flush && !fl_q) begin
        // unfilled positions are already zero, so padding is free
        fl_q <= 1'b1;
        if (cnt_q != '0) begin
          bv_q  <= 1'b1;
          bd_q  <= acc_q;
          acc_q <= '0;
          cnt_q <= '0;
        end
      end
    end
  end

endmodule : octet_packer

// ===== bench/byte_store_model.sv
// byte-wide store that keeps every octet the packer hands out
`timescale 1ns/1ns
module byte_store_model
  import ccitt_pack_pkg::*;
(
  input wire logic               clk_sys,
  input wire logic               rst,
  input wire logic               byte_valid,
  input wire logic [OCTET_W-1:0] byte_data
);
  logic [OCTET_W-1:0] got[$];

  // storage has no back-pressure, so every qualified octet is kept
  always @(posedge clk_sys) begin
    if (!rst && byte_valid)
      got.push_back(byte_data);
  end
endmodule : byte_store_model

// ===== bench/ccitt_stream_packer_chk.sv
// port-level assertions for the bi-level stream packer
`timescale 1ns/1ns
module ccitt_stream_packer_chk
  import ccitt_pack_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        seg_start,
  input wire logic [15:0] compression_sel,
  input wire logic        order_given,
  input wire logic [15:0] bit_packing_order,
  input wire logic        colour_sense_setting,
  input wire logic        code_valid,
  input wire logic        mkup_valid,
  input wire logic        in_ready,
  input wire logic        run_valid,
  input wire logic        run_black,
  input wire logic        pix_valid,
  input wire logic        pix_value,
  input wire logic        seg_done,
  input wire logic        restart,
  input wire logic        scheme_g3,
  input wire logic        scheme_g4,
  input wire logic        link_order_flag,
  input wire logic        order_unset,
  input wire logic        mode_bad,
  input wire logic        busy
);
  logic start_ok;
  logic good_sel;
  logic dark_q;

  // a start only counts while idle or halted
  assign start_ok = seg_start && !busy;
  assign good_sel = compression_sel == SCHEME_G3 ||
                    compression_sel == SCHEME_G4;

  // colour sense is latched per segment, so track it here
  always_ff @(posedge clk_sys) begin
    if (rst)
      dark_q <= 1'b0;
    else if (start_ok)
      dark_q <= colour_sense_setting;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_take;
    in_ready && (code_valid || mkup_valid);
  endsequence
  // word drains serially, then the window reopens within a bound
  sequence s_drain;
    !in_ready ##[1:40] in_ready;
  endsequence

  chk_word_take: assert property (s_take |=> s_drain)
    else $error("word hand-off window wrong");
  chk_pix_delay: assert property (pix_valid == $past(run_valid))
    else $error("pixel strobe not one cycle after run");
  chk_pix_colour: assert property (
    run_valid |=> pix_value == ($past(run_black) ^ dark_q))
    else $error("pixel colour wrong");
  chk_restart_good: assert property (
    start_ok && good_sel |=> restart ##1 !restart)
    else $error("no single restart on good start");
  chk_bad_halt: assert property (
    start_ok && !good_sel |=> mode_bad && !restart && !busy)
    else $error("bad selector not halted");
  chk_scheme_g4: assert property (
    start_ok && compression_sel == SCHEME_G4 |=> scheme_g4 && !scheme_g3)
    else $error("group 4 flags wrong");
  chk_link_flag: assert property (start_ok && order_given &&
    bit_packing_order == ORDER_LSB_FIRST |=> link_order_flag && !order_unset)
    else $error("link order flag missing");
  chk_order_unset: assert property (
    start_ok && !order_given |=> order_unset && !link_order_flag)
    else $error("unset order not flagged");
  chk_done_pulse: assert property ($rose(seg_done) |=> !seg_done)
    else $error("segment done longer than one cycle");
endmodule : ccitt_stream_packer_chk

bind ccitt_stream_packer ccitt_stream_packer_chk chk_u (
  .clk_sys(clk_sys), .rst(rst), .seg_start(seg_start),
  .compression_sel(compression_sel), .order_given(order_given),
  .bit_packing_order(bit_packing_order),
  .colour_sense_setting(colour_sense_setting), .code_valid(code_valid),
  .mkup_valid(mkup_valid), .in_ready(in_ready), .run_valid(run_valid),
  .run_black(run_black), .pix_valid(pix_valid), .pix_value(pix_value),
  .seg_done(seg_done), .restart(restart), .scheme_g3(scheme_g3),
  .scheme_g4(scheme_g4), .link_order_flag(link_order_flag),
  .order_unset(order_unset), .mode_bad(mode_bad), .busy(busy));

// ===== bench/ccitt_stream_packer_tb_top.sv
// self-checking bench for the bi-level stream packer
`timescale 1ns/1ns
module ccitt_stream_packer_tb_top;
  import ccitt_pack_pkg::*;
  logic                clk_sys = 1'b0;
  logic                rst = 1'b1;
  logic                seg_start, seg_end, order_given, colour_sense_setting;
  logic                code_valid, mkup_valid, run_valid, run_black;
  logic [15:0]         compression_sel, bit_packing_order;
  logic [CODE_W-1:0]   code_bits;
  logic [CLEN_W-1:0]   code_len;
  logic [RUN_W-1:0]    mkup_run;
  logic                in_ready, pix_valid, pix_value, byte_valid, restart;
  logic                seg_done, scheme_g3, scheme_g4, link_order_flag;
  logic                order_unset, mode_bad, run_bad, busy;
  logic [OCTET_W-1:0]  byte_data;
  logic [BYTES_W-1:0]  seg_bytes;
  int                  n_fail = 0;
  int                  comparisons = 0;
  int                  cycles = 0;
  logic                exp_q[$];
  // shared long-run codes, 1792 upward in steps of 64
  localparam logic [10:0] LONG_CODE [13] = '{11'h008, 11'h00C, 11'h00D,
    11'h012, 11'h013, 11'h014, 11'h015, 11'h016, 11'h017, 11'h01C,
    11'h01D, 11'h01E, 11'h01F};
  localparam logic [23:0] END_BLOCK = 24'h001001;

  always #25 clk_sys = ~clk_sys;

  ccitt_stream_packer dut_u (.clk_sys(clk_sys), .rst(rst),
    .seg_start(seg_start), .seg_end(seg_end),
    .compression_sel(compression_sel), .order_given(order_given),
    .bit_packing_order(bit_packing_order),
    .colour_sense_setting(colour_sense_setting), .code_valid(code_valid),
    .code_bits(code_bits), .code_len(code_len), .mkup_valid(mkup_valid),
    .mkup_run(mkup_run), .in_ready(in_ready), .run_valid(run_valid),
    .run_black(run_black), .pix_valid(pix_valid), .pix_value(pix_value),
    .byte_valid(byte_valid), .byte_data(byte_data), .seg_done(seg_done),
    .seg_bytes(seg_bytes), .restart(restart), .scheme_g3(scheme_g3),
    .scheme_g4(scheme_g4), .link_order_flag(link_order_flag),
    .order_unset(order_unset), .mode_bad(mode_bad), .run_bad(run_bad),
    .busy(busy));

  byte_store_model sink_u (.clk_sys(clk_sys), .rst(rst),
    .byte_valid(byte_valid), .byte_data(byte_data));

  task automatic chk_bit(input string nm, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  task automatic chk_vec(input string nm, input logic [15:0] e,
                         input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk_vec

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  // a hung hand-off must not stall the run for ever
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      stop_test();
    end
  end

  task automatic start_seg(input logic [15:0] sel, input logic given,
                           input logic [15:0] ord, input logic dark);
    @(negedge clk_sys);
    compression_sel = sel;
    order_given = given;
    bit_packing_order = ord;
    colour_sense_setting = dark;
    // segments are handed over whole; line counts are kept by this side
    seg_start = 1'b1;
    @(negedge clk_sys);
    seg_start = 1'b0;
    exp_q.delete();
    sink_u.got.delete();
  endtask : start_seg

  // bounded wait; a window that never opens shows as a mismatch
  task automatic wait_ready();
    int k;
    k = 0;
    while (in_ready !== 1'b1 && k < 200) begin
      @(negedge clk_sys);
      k++;
    end
    if (k == 200)
      chk_bit("in_ready", 1'b1, in_ready);
  endtask : wait_ready

  // one word or make-up request; n is the number of bits it must add
  task automatic send(input logic mk, input logic [12:0] b, input int n,
                      input logic [11:0] run);
    int i;
    wait_ready();
    code_valid = !mk;
    mkup_valid = mk;
    code_bits = b;
    code_len = n[3:0];
    mkup_run = run;
    for (i = n - 1; i >= 0; i--)
      exp_q.push_back(b[i]);
    @(negedge clk_sys);
    code_valid = 1'b0;
    mkup_valid = 1'b0;
  endtask : send

  task automatic pix(input logic blk, input logic e);
    run_black = blk;
    run_valid = 1'b1;
    @(negedge clk_sys);
    run_valid = 1'b0;
    chk_bit("pix_valid", 1'b1, pix_valid);
    chk_bit("pix_value", e, pix_value);
    // a quiet cycle so the next strobe is not rewritten in this step
    @(negedge clk_sys);
  endtask : pix

  task automatic end_seg(input logic lsb, input logic g4);
    int i;
    int k;
    logic [7:0] e;
    if (g4)
      for (i = 23; i >= 0; i--)
        exp_q.push_back(END_BLOCK[i]);
    while (exp_q.size() % 8 != 0)
      exp_q.push_back(1'b0);
    wait_ready();
    seg_end = 1'b1;
    @(negedge clk_sys);
    seg_end = 1'b0;
    k = 0;
    while (seg_done !== 1'b1 && k < 400) begin
      @(negedge clk_sys);
      k++;
    end
    chk_bit("seg_done", 1'b1, seg_done);
    chk_vec("seg_bytes", 16'(exp_q.size() / 8), seg_bytes);
    chk_vec("octets", 16'(exp_q.size() / 8), 16'(sink_u.got.size()));
    for (i = 0; i < exp_q.size(); i++) begin
      e[lsb ? i % 8 : 7 - i % 8] = exp_q[i];
      if (i % 8 == 7)
        chk_vec("byte_data", {8'h00, e}, {8'h00, sink_u.got[i / 8]});
    end
  endtask : end_seg

  task automatic t_bad_sel();
    start_seg(16'h0005, 1'b1, ORDER_MSB_FIRST, 1'b0);
    chk_bit("restart", 1'b0, restart);
    chk_bit("mode_bad", 1'b1, mode_bad);
    chk_bit("busy", 1'b0, busy);
    $display("test bad selector done");
  endtask : t_bad_sel

  task automatic t_g3();
    start_seg(SCHEME_G3, 1'b0, 16'h0000, 1'b0);
    chk_bit("restart", 1'b1, restart);
    chk_bit("scheme_g3", 1'b1, scheme_g3);
    chk_bit("scheme_g4", 1'b0, scheme_g4);
    chk_bit("order_unset", 1'b1, order_unset);
    chk_bit("link_order_flag", 1'b0, link_order_flag);
    pix(1'b1, 1'b1);
    pix(1'b0, 1'b0);
    send(1'b0, 13'h1ABC, 13, 12'h000);
    send(1'b0, 13'h0001, 12, 12'h000);
    send(1'b0, 13'h0005, 3, 12'h000);
    end_seg(1'b0, 1'b0);
    $display("test group 3 default order done");
  endtask : t_g3

  task automatic t_g4();
    int i;
    start_seg(SCHEME_G4, 1'b1, ORDER_LSB_FIRST, 1'b1);
    chk_bit("scheme_g4", 1'b1, scheme_g4);
    chk_bit("link_order_flag", 1'b1, link_order_flag);
    chk_bit("order_unset", 1'b0, order_unset);
    pix(1'b0, 1'b1);
    pix(1'b1, 1'b0);
    for (i = 0; i < 13; i++)
      send(1'b1, {2'b00, LONG_CODE[i]}, i < 3 ? 10 : 11,
           12'(1792 + 64 * i));
    send(1'b1, 13'h0000, 0, 12'h708);
    chk_bit("run_bad", 1'b1, run_bad);
    send(1'b0, 13'h00B3, 9, 12'h000);
    end_seg(1'b1, 1'b1);
    $display("test group 4 link order done");
  endtask : t_g4

  // an unknown order value is reported and falls back to order 1
  task automatic t_bad_order();
    start_seg(SCHEME_G3, 1'b1, 16'h0003, 1'b0);
    chk_bit("mode_bad", 1'b1, mode_bad);
    chk_bit("link_order_flag", 1'b0, link_order_flag);
    chk_bit("order_unset", 1'b0, order_unset);
    chk_bit("busy", 1'b1, busy);
    send(1'b0, 13'h00A7, 8, 12'h000);
    end_seg(1'b0, 1'b0);
    $display("test unknown order done");
  endtask : t_bad_order

  initial begin
    seg_start = 1'b0;
    seg_end = 1'b0;
    order_given = 1'b0;
    colour_sense_setting = 1'b0;
    code_valid = 1'b0;
    mkup_valid = 1'b0;
    run_valid = 1'b0;
    run_black = 1'b0;
    compression_sel = 16'h0000;
    bit_packing_order = 16'h0000;
    code_bits = 13'h0000;
    code_len = 4'h0;
    mkup_run = 12'h000;
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    t_bad_sel();
    t_g3();
    t_g4();
    t_bad_order();
    stop_test();
  end
endmodule : ccitt_stream_packer_tb_top
